// [core/iosf_map.vh]
`ifndef IOSF_MAP_VH
`define IOSF_MAP_VH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define IOSF_REG_CTRL      8'h00
`define IOSF_REG_STATUS    8'h04
`define IOSF_REG_FRAMES    8'h08
`define IOSF_REG_DROPPED   8'h0C

// ************************************************************
// control fields and reset values
// ************************************************************
`define IOSF_CTRL_API_BIT  0
`define IOSF_CTRL_FMT_BIT  1
`define IOSF_CTRL_RESET    2'h1

// ************************************************************
// frame constants
// ************************************************************
`define IOSF_START_DELIM   8'h7E
`define IOSF_FRAME_TYPE    8'h92
`define IOSF_SAMPLE_COUNT  8'h01
`define IOSF_CSUM_BASE     8'hFF
`define IOSF_DIG_USED      16'h1CFF
`define IOSF_ANA_USED      8'h8F
`define IOSF_LEN_FIXED     16'h0010
`define IOSF_POS_TYPE      5'h03
`define IOSF_POS_LAST_HEAD 5'h12
`define IOSF_ANA_CHANNELS  3'h5
`define IOSF_SUPPLY_BIT    7

`endif

// [core/iosf_skid_buf.v]
`timescale 1ns/10ps

// ************************************************************
// two-entry buffer, registered outputs on both sides
// ************************************************************
module iosf_skid_buf #(
    parameter WIDTH = 8
) (
    input  wire             clk,       // system clock
    input  wire             reset,     // sync reset, active high
    input  wire [WIDTH-1:0] inData,    // word from producer
    input  wire             inValid,   // producer has a word
    output wire             inReady,   // room for a word
    output wire [WIDTH-1:0] outData,   // head word
    output wire             outValid,  // head word present
    input  wire             outReady   // consumer takes head
);
    reg [WIDTH-1:0] head_ff;
    reg [WIDTH-1:0] tail_ff;
    reg             headVld_ff;
    reg             tailVld_ff;
    wire            push;
    wire            pop;

    assign inReady  = ~tailVld_ff;
    assign outData  = head_ff;
    assign outValid = headVld_ff;
    assign push     = inValid & ~tailVld_ff;
    assign pop      = headVld_ff & outReady;

    always @(posedge clk) begin
        if (reset) begin
            head_ff    <= {WIDTH{1'b0}};
            tail_ff    <= {WIDTH{1'b0}};
            headVld_ff <= 1'b0;
            tailVld_ff <= 1'b0;
        end else if (pop) begin
            head_ff    <= tailVld_ff ? tail_ff : inData;
            headVld_ff <= tailVld_ff | push;
            tailVld_ff <= 1'b0;
        end else if (push) begin
            if (headVld_ff) begin
                tail_ff    <= inData;
                tailVld_ff <= 1'b1;
            end else begin
                head_ff    <= inData;
                headVld_ff <= 1'b1;
            end
        end
    end
endmodule

// [core/iosf_frame_builder.v]
// Function
// [RL1] sample frame carries type 0x92, standard format
// [RL2] samples forwarded only in API mode
// [RL3] 64-bit sender address, offsets 4-11, MSB first
// [RL4] 16-bit network address, offsets 12-13, MSB first
// [RL5] receive options at 14: ack, broadcast
// [RL6] host ignores other option bits
// [RL7] sample count at 15, always one
// [RL8] digital channel mask at offsets 16-17
// [RL9] digital mask bits 0-7, 10-12 used
// [RL10] analog channel mask at offset 18
// [RL11] analog bits 0-3 inputs, top bit supply
// [RL12] digital samples 19-20 only if mask nonzero
// [RL13] disabled digital lines report zero
// [RL14] sample bits placed like mask bits
// [RL15] two bytes per enabled analog input
// [RL16] analog values in ascending input order
// [RL17] delimiter then big-endian length at 0-2
// [RL18] checksum is 0xFF minus data byte sum
`timescale 1ns/10ps
`include "iosf_map.vh"

module iosf_frame_builder (
    input  wire        clk,          // system clock, 100 MHz
    input  wire        reset,        // sync reset, active high
    input  wire [7:0]  regAddr,      // register byte address
    input  wire [31:0] regWrData,    // register write data
    input  wire        regWr,        // register write strobe
    input  wire        regRd,        // register read strobe
    output reg  [31:0] regRdData,    // read data, cycle after strobe
    input  wire        sampleValid,  // remote sample offered
    output reg         sampleReady,  // sample accepted when both high
    input  wire [63:0] srcAddr64,    // sender 64-bit address
    input  wire [15:0] srcAddr16,    // sender network address
    input  wire [7:0]  rxOptions,    // receive option flags
    input  wire [15:0] digMask,      // digital channel mask
    input  wire [7:0]  anaMask,      // analog channel mask
    input  wire [15:0] digStates,    // raw digital line states
    input  wire [79:0] anaValues,    // supply,in3..in0, 16 bit each
    output wire [7:0]  txData,       // frame byte to host port
    output wire        txValid,      // frame byte present
    input  wire        txReady       // host port takes byte
);
    // ************************************************************
    // states
    // ************************************************************
    localparam ST_IDLE = 3'd0;
    localparam ST_HEAD = 3'd1;
    localparam ST_DIG  = 3'd2;
    localparam ST_ANA  = 3'd3;
    localparam ST_SUM  = 3'd4;
    localparam [1:0] CTRL_RST = `IOSF_CTRL_RESET;

    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg  [4:0]  pos_ff;
    reg  [4:0]  nxt_pos;
    reg  [2:0]  chan_ff;
    reg  [2:0]  nxt_chan;
    reg         lowHalf_ff;
    reg         nxt_lowHalf;
    reg  [7:0]  sum_ff;
    reg  [7:0]  nxt_sum;
    reg  [63:0] src64_ff;
    reg  [15:0] src16_ff;
    reg  [7:0]  opt_ff;
    reg  [15:0] dmask_ff;
    reg  [7:0]  amask_ff;
    reg  [15:0] dstat_ff;
    reg  [79:0] ana_ff;
    reg         apiMode_ff;
    reg         explicitFmt_ff;
    reg  [15:0] frames_ff;
    reg  [15:0] dropped_ff;
    reg  [7:0]  emitByte;
    reg         emitValid;
    wire        bufInReady;
    wire        take;
    wire        accept;
    wire        forward;
    wire [15:0] frameLen;
    wire        chanOn;
    wire [15:0] chanVal;

    // ************************************************************
    // helper functions
    // ************************************************************
    // analog slot 0..3 are inputs, slot 4 is the supply bit
    function chanEnabled;
        input [7:0] mask;
        input [2:0] slot;
        begin
            if (slot == 3'd4)
                chanEnabled = mask[`IOSF_SUPPLY_BIT];
            else
                chanEnabled = mask[slot[1:0]];
        end
    endfunction

    function [2:0] anaCount;
        input [7:0] mask;
        begin
            anaCount = {2'b00, mask[0]} + {2'b00, mask[1]}
                     + {2'b00, mask[2]} + {2'b00, mask[3]}
                     + {2'b00, mask[`IOSF_SUPPLY_BIT]};
        end
    endfunction

    // ************************************************************
    // sample intake
    // ************************************************************
    assign accept  = sampleValid & sampleReady;
    // explicit format or non-API mode swallow the sample
    assign forward = apiMode_ff & ~explicitFmt_ff;  // see [RL1] see [RL2]

    always @(posedge clk) begin
        if (reset) begin
            src64_ff <= 64'h0000_0000_0000_0000;
            src16_ff <= 16'h0000;
            opt_ff   <= 8'h00;
            dmask_ff <= 16'h0000;
            amask_ff <= 8'h00;
            dstat_ff <= 16'h0000;
            ana_ff   <= 80'h0000_0000_0000_0000_0000;
        end else if (accept) begin
            src64_ff <= srcAddr64;
            src16_ff <= srcAddr16;
            // other option bits pass through for the host to ignore
            opt_ff   <= rxOptions;                       // see [RL5]
            dmask_ff <= digMask & `IOSF_DIG_USED;        // see [RL9]
            amask_ff <= anaMask & `IOSF_ANA_USED;        // see [RL11]
            // unsampled lines forced low
            dstat_ff <= digStates & digMask & `IOSF_DIG_USED; // see [RL13]
            ana_ff   <= anaValues;
        end
    end

    // length excludes delimiter, length field and checksum
    assign frameLen = `IOSF_LEN_FIXED
                    + ((dmask_ff != 16'h0000) ? 16'h0002 : 16'h0000)
                    + {12'h000, anaCount(amask_ff), 1'b0}; // see [RL17]

    assign chanOn  = chanEnabled(amask_ff, chan_ff);
    assign chanVal = ana_ff[{chan_ff, 4'h0} +: 16];

    // ************************************************************
    // byte selection
    // ************************************************************
    always @* begin
        emitByte  = 8'h00;
        emitValid = 1'b0;
        case (state_ff)
            ST_HEAD: begin
                emitValid = 1'b1;
                case (pos_ff)
                    5'd0:  emitByte = `IOSF_START_DELIM;  // see [RL17]
                    5'd1:  emitByte = frameLen[15:8];     // see [RL17]
                    5'd2:  emitByte = frameLen[7:0];
                    5'd3:  emitByte = `IOSF_FRAME_TYPE;   // see [RL1]
                    5'd4:  emitByte = src64_ff[63:56];    // see [RL3]
                    5'd5:  emitByte = src64_ff[55:48];
                    5'd6:  emitByte = src64_ff[47:40];
                    5'd7:  emitByte = src64_ff[39:32];
                    5'd8:  emitByte = src64_ff[31:24];
                    5'd9:  emitByte = src64_ff[23:16];
                    5'd10: emitByte = src64_ff[15:8];
                    5'd11: emitByte = src64_ff[7:0];
                    5'd12: emitByte = src16_ff[15:8];     // see [RL4]
                    5'd13: emitByte = src16_ff[7:0];
                    5'd14: emitByte = opt_ff;             // see [RL5]
                    5'd15: emitByte = `IOSF_SAMPLE_COUNT; // see [RL7]
                    5'd16: emitByte = dmask_ff[15:8];     // see [RL8]
                    5'd17: emitByte = dmask_ff[7:0];
                    5'd18: emitByte = amask_ff;           // see [RL10]
                    default: emitByte = 8'h00;
                endcase
            end
            ST_DIG: begin
                emitValid = 1'b1;
                // same bit layout as the mask
                emitByte  = pos_ff[0] ? dstat_ff[7:0]
                                      : dstat_ff[15:8];   // see [RL14]
            end
            ST_ANA: begin
                emitValid = chanOn;                       // see [RL15]
                emitByte  = lowHalf_ff ? chanVal[7:0] : chanVal[15:8];
            end
            ST_SUM: begin
                emitValid = 1'b1;
                emitByte  = `IOSF_CSUM_BASE - sum_ff;     // see [RL18]
            end
            default: begin
                emitByte  = 8'h00;
                emitValid = 1'b0;
            end
        endcase
    end

    assign take = emitValid & bufInReady;

    // ************************************************************
    // sequencer
    // ************************************************************
    always @* begin
        nxt_state   = state_ff;
        nxt_pos     = pos_ff;
        nxt_chan    = chan_ff;
        nxt_lowHalf = lowHalf_ff;
        nxt_sum     = sum_ff;
        if (take && (state_ff != ST_SUM) &&
            !(state_ff == ST_HEAD && pos_ff < `IOSF_POS_TYPE))
            nxt_sum = sum_ff + emitByte;                  // see [RL18]
        case (state_ff)
            ST_IDLE: begin
                if (accept && forward) begin
                    nxt_state = ST_HEAD;
                    nxt_pos   = 5'd0;
                    nxt_sum   = 8'h00;
                end
            end
            ST_HEAD: begin
                if (take) begin
                    nxt_pos = pos_ff + 5'd1;
                    if (pos_ff == `IOSF_POS_LAST_HEAD) begin
                        nxt_pos  = 5'd0;
                        nxt_chan = 3'd0;
                        nxt_lowHalf = 1'b0;
                        if (dmask_ff != 16'h0000)
                            nxt_state = ST_DIG;           // see [RL12]
                        else
                            nxt_state = ST_ANA;
                    end
                end
            end
            ST_DIG: begin
                if (take) begin
                    nxt_pos = pos_ff + 5'd1;
                    if (pos_ff[0])
                        nxt_state = ST_ANA;
                end
            end
            ST_ANA: begin
                // walk slots upward; disabled ones cost one idle cycle
                if (!chanOn || (take && lowHalf_ff)) begin
                    nxt_lowHalf = 1'b0;
                    nxt_chan    = chan_ff + 3'd1;         // see [RL16]
                    if (chan_ff == `IOSF_ANA_CHANNELS - 3'd1)
                        nxt_state = ST_SUM;
                end else if (take) begin
                    nxt_lowHalf = 1'b1;
                end
            end
            ST_SUM: begin
                if (take)
                    nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            state_ff    <= ST_IDLE;
            pos_ff      <= 5'd0;
            chan_ff     <= 3'd0;
            lowHalf_ff  <= 1'b0;
            sum_ff      <= 8'h00;
            sampleReady <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            pos_ff      <= nxt_pos;
            chan_ff     <= nxt_chan;
            lowHalf_ff  <= nxt_lowHalf;
            sum_ff      <= nxt_sum;
            // dropped at the handshake so a taken sample never repeats
            sampleReady <= (nxt_state == ST_IDLE) && !accept;
        end
    end

    // ************************************************************
    // output buffer
    // ************************************************************
    // absorbs host stalls so no byte is lost mid-frame
    iosf_skid_buf #(
        .WIDTH    (8)
    ) u_buf (
        .clk      (clk),
        .reset    (reset),
        .inData   (emitByte),
        .inValid  (emitValid),
        .inReady  (bufInReady),
        .outData  (txData),
        .outValid (txValid),
        .outReady (txReady)
    );

    // ************************************************************
    // register port
    // ************************************************************
    always @(posedge clk) begin
        if (reset) begin
            apiMode_ff     <= CTRL_RST[`IOSF_CTRL_API_BIT];
            explicitFmt_ff <= CTRL_RST[`IOSF_CTRL_FMT_BIT];
            frames_ff      <= 16'h0000;
            dropped_ff     <= 16'h0000;
            regRdData      <= 32'h0000_0000;
        end else begin
            if (regWr && regAddr == `IOSF_REG_CTRL) begin
                apiMode_ff     <= regWrData[`IOSF_CTRL_API_BIT];
                explicitFmt_ff <= regWrData[`IOSF_CTRL_FMT_BIT];
            end
            if (state_ff == ST_SUM && take)
                frames_ff <= frames_ff + 16'h0001;
            if (accept && !forward)
                dropped_ff <= dropped_ff + 16'h0001;      // see [RL2]
            regRdData <= 32'h0000_0000;
            if (regRd) begin
                case (regAddr)
                    `IOSF_REG_CTRL:
                        regRdData <= {30'h0, explicitFmt_ff, apiMode_ff};
                    `IOSF_REG_STATUS:
                        regRdData <= {29'h0, state_ff};
                    `IOSF_REG_FRAMES:
                        regRdData <= {16'h0000, frames_ff};
                    `IOSF_REG_DROPPED:
                        regRdData <= {16'h0000, dropped_ff};
                    default:
                        regRdData <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// [bench/iosf_host_model.sv]
`timescale 1ns/10ps
// ********
// host side of the serial port
// ********
module iosf_host_model (
    input  wire       clk,      // system clock
    input  wire       reset,    // sync reset, active high
    input  wire [7:0] txData,   // frame byte from the block
    input  wire       txValid,  // frame byte present
    output logic      txReady,  // byte taken when both high
    input  wire       slow      // take one cycle in four
);
    logic [7:0] got[$];
    logic [1:0] phase_ff;

    // slow mode keeps the two-entry buffer full most of the time
    always @(posedge clk) begin
        if (reset) begin
            txReady  <= 1'b0;
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
            txReady  <= !slow || phase_ff == 2'h3;
            if (txValid && txReady) got.push_back(txData);
        end
    end

    // frame trusted only if bytes from type on sum to 0xff
    function automatic logic sumOk(input int first, input int last);
        logic [7:0] s;
        s = 8'h00;
        for (int i = first + 3; i <= last; i++) s += got[i];
        return s == 8'hFF;
    endfunction

    function automatic logic [1:0] flags(input int first);
        return got[first + 14][1:0];
    endfunction
endmodule

// [bench/iosf_frame_props.sv]
`timescale 1ns/10ps
// ********
// frame byte and bus checks
// ********
module iosf_frame_props (
    input wire        clk,        // system clock
    input wire        reset,      // sync reset
    input wire        regRd,      // read strobe
    input wire [31:0] regRdData,  // read data
    input wire [7:0]  txData,     // frame byte
    input wire        txValid,    // byte present
    input wire        txReady     // byte taken
);
    wire       hs = txValid && txReady;
    reg  [7:0] idx_ff;  // offset of byte in frame
    reg  [7:0] len_ff;
    reg  [7:0] sum_ff;
    // length unknown before offset 3, hence the floor
    wire       lastB = idx_ff > 8'h03 && idx_ff == len_ff + 8'h03;

    always @(posedge clk) begin
        if (reset) begin
            idx_ff <= 8'h00;
            len_ff <= 8'hFF;
            sum_ff <= 8'h00;
        end else if (hs) begin
            idx_ff <= lastB ? 8'h00 : idx_ff + 8'h01;
            sum_ff <= idx_ff < 8'h03 ? 8'h00 : sum_ff + txData;
            if (idx_ff == 8'h02) len_ff <= txData;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_rdIdle; !$past(regRd) |-> regRdData == 32'h0000_0000;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("stray read data");
    property p_hold; txValid && !txReady |=> txValid && $stable(txData);
    endproperty
    a_hold: assert property (p_hold) else $error("byte lost in stall");
    property p_delim; hs && idx_ff == 8'h00 |-> txData == 8'h7E; endproperty
    a_delim: assert property (p_delim) else $error("bad start");
    property p_lenHi; hs && idx_ff == 8'h01 |-> txData == 8'h00; endproperty
    a_lenHi: assert property (p_lenHi) else $error("bad len");
    property p_type; hs && idx_ff == 8'h03 |-> txData == 8'h92; endproperty
    a_type: assert property (p_type) else $error("bad type");
    property p_count; hs && idx_ff == 8'h0F |-> txData == 8'h01; endproperty
    a_count: assert property (p_count) else $error("bad count");
    property p_dmask; hs && idx_ff == 8'h10 |-> (txData & 8'hE3) == 8'h00;
    endproperty
    a_dmask: assert property (p_dmask) else $error("dig mask");
    property p_amask; hs && idx_ff == 8'h12 |-> (txData & 8'h70) == 8'h00;
    endproperty
    a_amask: assert property (p_amask) else $error("ana mask");
    property p_sum; hs && lastB |-> txData == 8'hFF - sum_ff; endproperty
    a_sum: assert property (p_sum) else $error("bad checksum");

    c_frame: cover property (hs && lastB);
    c_stall: cover property (txValid && !txReady);
    c_read: cover property (regRd);
endmodule

bind iosf_frame_builder iosf_frame_props u_props (
    .clk(clk), .reset(reset), .regRd(regRd), .regRdData(regRdData),
    .txData(txData), .txValid(txValid), .txReady(txReady)
);

// [bench/iosf_frame_builder_tb.sv]
`timescale 1ns/10ps
`include "iosf_map.vh"
module iosf_frame_builder_tb;
    logic        clk, reset, regWr, regRd, sampleValid, slow;
    logic [7:0]  regAddr, rxOptions, anaMask;
    logic [15:0] srcAddr16, digMask, digStates;
    logic [31:0] regWrData;
    logic [63:0] srcAddr64;
    logic [79:0] anaValues;
    wire  [31:0] regRdData;
    wire  [7:0]  txData;
    wire         sampleReady, txValid, txReady;
    logic [7:0]  expq[$];
    int          failures, tests_run, cycles;

    iosf_frame_builder DUT (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .srcAddr64(srcAddr64),
        .srcAddr16(srcAddr16), .rxOptions(rxOptions), .digMask(digMask),
        .anaMask(anaMask), .digStates(digStates), .anaValues(anaValues),
        .txData(txData), .txValid(txValid), .txReady(txReady));
    iosf_host_model host (.clk(clk), .reset(reset), .txData(txData),
        .txValid(txValid), .txReady(txReady), .slow(slow));

    always #5 clk = !clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input [7:0] a, input [31:0] d);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        // idle edge: a following write never re-drives regWr in one step
        @(posedge clk);
    endtask

    task automatic rd(input [7:0] a, input [31:0] want);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        chk(regRdData, want);
    endtask

    task automatic build(input [63:0] a, input [15:0] n, input [7:0] o,
            input [15:0] dm, input [7:0] am, input [15:0] ds,
            input [79:0] av);
        logic [7:0]  f[$];
        logic [15:0] d;
        logic [7:0]  m, s;
        d = dm & 16'h1CFF;
        m = am & 8'h8F;
        f = {8'h92, a[63:56], a[55:48], a[47:40], a[39:32], a[31:24],
             a[23:16], a[15:8], a[7:0], n[15:8], n[7:0], o, 8'h01,
             d[15:8], d[7:0], m};
        if (d != 16'h0000) f = {f, ds[15:8] & d[15:8], ds[7:0] & d[7:0]};
        for (int i = 0; i < 5; i++)
            if (m[i == 4 ? 7 : i]) f = {f, av[16*i+8 +: 8], av[16*i +: 8]};
        s = 8'h00;
        foreach (f[j]) s += f[j];
        expq = {expq, 8'h7E, 8'h00, 8'(f.size()), f, 8'hFF - s};
    endtask

    // 64-bit address, line states and analog values are scrambled after the accept edge to prove capture there
    task automatic offer(input [63:0] a, input [15:0] n, input [7:0] o,
            input [15:0] dm, input [7:0] am, input [15:0] ds,
            input [79:0] av, input logic want);
        int t;
        if (want) build(a, n, o, dm, am, ds, av);
        {srcAddr64, srcAddr16, rxOptions} <= {a, n, o};
        {digMask, anaMask, digStates, anaValues} <= {dm, am, ds, av};
        sampleValid <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (!sampleReady && t < 500);
        // a sample never taken counts as a mismatch
        chk(sampleReady, 1'b1);
        sampleValid <= 1'b0;
        {srcAddr64, digStates, anaValues} <= ~{a, ds, av};
    endtask

    task automatic drain();
        int t;
        t = 0;
        while (host.got.size() < expq.size() && t < 3000) begin
            @(posedge clk);
            t++;
        end
        repeat (8) @(posedge clk);
        chk(host.got.size(), expq.size());
        foreach (expq[i])
            chk(host.got[i], expq[i]);
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {regWr, regRd, sampleValid, slow, regAddr, regWrData} = '0;
        {srcAddr64, srcAddr16, rxOptions, digMask} = '0;
        {anaMask, digStates, anaValues, failures, tests_run, cycles} = '0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(`IOSF_REG_CTRL, 32'h0000_0001);
        rd(`IOSF_REG_FRAMES, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        offer(64'h0013_A200_4052_2BAA, 16'h7D84, 8'h01, 16'h001C, 8'h02,
              16'hE3F4, 80'h1111_2222_3333_0225_4444, 1'b1);
        drain();
        chk(host.got[2], 8'h14);
        chk(host.got[23], 8'hF5);
        chk(host.sumOk(0, 23), 1'b1);
        chk(host.flags(0), 2'h1);
        host.got = {};
        expq = {};
        // busy block must hold the second sample off until queued
        slow <= 1'b1;
        offer(64'hFEDC_BA98_7654_3210, 16'hA55A, 8'hE3, 16'hFFFF, 8'hFF,
              16'hFFFF, 80'h0102_0304_0506_0708_090A, 1'b1);
        @(posedge clk);
        offer(64'h1, 16'hFFFE, 8'h02, 16'h0, 8'h0, 16'hFFFF, 80'h5, 1'b1);
        drain();
        host.got = {};
        expq = {};
        slow <= 1'b0;
        wr(`IOSF_REG_CTRL, 32'h0000_0000);
        offer(64'h2, 16'h3, 8'h01, 16'h00FF, 8'h01, 16'h00AA, 80'h7, 1'b0);
        repeat (40) @(posedge clk);
        chk(host.got.size(), 0);
        wr(`IOSF_REG_CTRL, 32'h0000_0003);
        offer(64'h2, 16'h3, 8'h01, 16'h00FF, 8'h01, 16'h00AA, 80'h7, 1'b0);
        repeat (40) @(posedge clk);
        chk(host.got.size(), 0);
        rd(`IOSF_REG_DROPPED, 32'h0000_0002);
        wr(8'h10, 32'h0000_0000);
        wr(`IOSF_REG_CTRL, 32'h0000_0001);
        rd(`IOSF_REG_CTRL, 32'h0000_0001);
        offer(64'h9, 16'h8, 8'h40, 16'h1C00, 8'h80, 16'h1400,
              80'hBEEF_0000_0000_0000_0000, 1'b1);
        drain();
        rd(`IOSF_REG_FRAMES, 32'h0000_0004);
        rd(`IOSF_REG_STATUS, 32'h0000_0000);
        wrap_up();
    end
endmodule
